// >>> hdl/phu_pkg.sv
// Package of constants and types for the prefetch hint unit
package phu_pkg;

  // Instruction fields
  localparam logic [5:0] PHU_MAJOR_GROUP_C = 6'h18;
  localparam logic [3:0] PHU_DATA_PREFETCH_INSTR_MINOR    = 4'h2;
  localparam int         PHU_MAJOR_POS     = 26;
  localparam int         PHU_HINT_POS      = 21;
  localparam int         PHU_BASE_POS      = 16;
  localparam int         PHU_MINOR_POS     = 12;
  localparam int         PHU_OFFSET_W      = 12;

  // Hint codes
  localparam logic [4:0] PHU_HINT_LOAD      = 5'h00;
  localparam logic [4:0] PHU_HINT_STORE     = 5'h01;
  localparam logic [4:0] PHU_HINT_LOAD_STR  = 5'h04;
  localparam logic [4:0] PHU_HINT_STORE_STR = 5'h05;
  localparam logic [4:0] PHU_HINT_LOAD_RET  = 5'h06;
  localparam logic [4:0] PHU_HINT_STORE_RET = 5'h07;
  localparam logic [4:0] PHU_HINT_WB_INV    = 5'h19;
  localparam logic [4:0] PHU_HINT_ZERO_FILL = 5'h1E;

  // Cache action requested of the hierarchy
  typedef enum logic [2:0] {
    PHU_ACT_NONE      = 3'h0,
    PHU_ACT_FETCH_RD  = 3'h1,
    PHU_ACT_FETCH_WR  = 3'h2,
    PHU_ACT_WB_INV    = 3'h3,
    PHU_ACT_ZERO_FILL = 3'h4
  } phu_action_type;

  // Placement class for replacement policy
  typedef enum logic [1:0] {
    PHU_PLACE_NORMAL   = 2'h0,
    PHU_PLACE_STREAMED = 2'h1,
    PHU_PLACE_RETAINED = 2'h2
  } phu_place_type;

  typedef enum logic [3:0] {
    PHU_ST_IDLE  = 4'b0001,
    PHU_ST_XLATE = 4'b0010,
    PHU_ST_ISSUE = 4'b0100,
    PHU_ST_WAIT  = 4'b1000
  } phu_state_type;

  localparam logic [31:0] PHU_ADDR_RESET = 32'h0000_0000;

endpackage

// >>> hdl/phu_prefetch_hint_unit.sv
// Prefetch hint unit: decode, address, translate and issue cache action
// ----------------------------------------------------------------------------
// Summary of operation
// - Decode group C opcode, minor 0010
// - Address is base plus sign-extended offset, translated
// - Never raise address or translation exceptions
// - Faulting address: drop fault, move no data
// - Any action allowed if invisible; zero-fill excepted
// - Only bus or cache errors may report
// - Uncached address: no memory operation at all
// - Operation uses the address's own attributes
// - Cached address fetches block containing address
// - Coherent attribute makes coherent transaction
// - Obey memory ordering barrier rules
// - Hint 0 read fetch, hint 1 write fetch
// - Hints 4,5 streamed, spare retained lines
// - Hints 6,7 retained, safe from streamed fills
// - Hints 2-3, 8-20 reserved, no meaning
// - Hints 21-24, 26-29, 31 implementation defined
// - Hint 25 writeback dirty then invalidate
// - Hint 30 zero-fill allocate on miss only
// - Locked lines never changed by prefetch
// ----------------------------------------------------------------------------
`timescale 1ns/1ps

module phu_prefetch_hint_unit (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  // Issue from pipeline
  input  wire logic                         issueValid,
  output logic                              issueReady,
  input  wire logic [31:0]                  issueInstr,
  input  wire logic [31:0]                  baseValue,
  output logic [4:0]                        baseSelect,
  output logic                              isPrefetch,
  output logic                              doneValid,
  output logic                              regWriteEnable,
  // Address translation
  output logic                              xlateReq,
  output logic [31:0]                       xlateVaddr,
  input  wire logic                         xlateDone,
  input  wire logic [31:0]                  xlatePaddr,
  input  wire logic                         xlateFault,
  input  wire logic                         xlateUncached,
  input  wire logic                         xlateCoherent,
  input  wire logic [2:0]                   xlateAttr,
  // Cache and memory hierarchy
  input  wire logic                         syncPending,
  output logic                              cacheReqValid,
  input  wire logic                         cacheReqReady,
  output phu_pkg::phu_action_type           cacheAction,
  output phu_pkg::phu_place_type            cachePlace,
  output logic [31:0]                       cacheAddr,
  output logic [2:0]                        cacheAttr,
  output logic                              cacheCoherent,
  output logic                              cacheSkipLocked,
  input  wire logic                         cacheDone,
  input  wire logic                         cacheBusError,
  input  wire logic                         cacheEccError,
  output logic                              errorReport
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    phu_pkg::phu_state_type  state;
    phu_pkg::phu_action_type action;
    phu_pkg::phu_place_type  place;
    logic [31:0]             addr;
    logic [2:0]              attr;
    logic                    coherent;
    logic                    done;
    logic                    err;
  } phu_regs_type;

  phu_regs_type regs_reg;
  phu_regs_type regs_next;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  logic [4:0]  hint;
  logic [11:0] offset;
  logic        match;
  phu_pkg::phu_action_type decAction;
  phu_pkg::phu_place_type  decPlace;

  assign hint   = issueInstr[phu_pkg::PHU_HINT_POS +: 5];
  assign offset = issueInstr[phu_pkg::PHU_OFFSET_W-1:0];
  assign match  = (issueInstr[phu_pkg::PHU_MAJOR_POS +: 6] == phu_pkg::PHU_MAJOR_GROUP_C)
               && (issueInstr[phu_pkg::PHU_MINOR_POS +: 4] == phu_pkg::PHU_DATA_PREFETCH_INSTR_MINOR);

  assign baseSelect = issueInstr[phu_pkg::PHU_BASE_POS +: 5];
  assign isPrefetch = match;

  always_comb begin
    decAction = phu_pkg::PHU_ACT_NONE;
    decPlace  = phu_pkg::PHU_PLACE_NORMAL;
    case (hint)
      phu_pkg::PHU_HINT_LOAD: begin
        decAction = phu_pkg::PHU_ACT_FETCH_RD;
      end
      phu_pkg::PHU_HINT_STORE: begin
        decAction = phu_pkg::PHU_ACT_FETCH_WR;
      end
      phu_pkg::PHU_HINT_LOAD_STR: begin
        decAction = phu_pkg::PHU_ACT_FETCH_RD;
        decPlace  = phu_pkg::PHU_PLACE_STREAMED;
      end
      phu_pkg::PHU_HINT_STORE_STR: begin
        decAction = phu_pkg::PHU_ACT_FETCH_WR;
        decPlace  = phu_pkg::PHU_PLACE_STREAMED;
      end
      phu_pkg::PHU_HINT_LOAD_RET: begin
        decAction = phu_pkg::PHU_ACT_FETCH_RD;
        decPlace  = phu_pkg::PHU_PLACE_RETAINED;
      end
      phu_pkg::PHU_HINT_STORE_RET: begin
        decAction = phu_pkg::PHU_ACT_FETCH_WR;
        decPlace  = phu_pkg::PHU_PLACE_RETAINED;
      end
      phu_pkg::PHU_HINT_WB_INV: begin
        decAction = phu_pkg::PHU_ACT_WB_INV;
      end
      phu_pkg::PHU_HINT_ZERO_FILL: begin
        decAction = phu_pkg::PHU_ACT_ZERO_FILL;
      end
      // Reserved and spare codes are left unassigned on purpose
      default: begin
        decAction = phu_pkg::PHU_ACT_NONE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    regs_next      = regs_reg;
    regs_next.done = 1'b0;
    regs_next.err  = 1'b0;
    case (regs_reg.state)
      phu_pkg::PHU_ST_IDLE: begin
        if (issueValid && match) begin
          // Offset sign-extended to 32 bits before the add
          regs_next.addr   = baseValue + {{20{offset[11]}}, offset};
          regs_next.action = decAction;
          regs_next.place  = decPlace;
          if (decAction == phu_pkg::PHU_ACT_NONE) begin
            regs_next.done = 1'b1;
          end else begin
            regs_next.state = phu_pkg::PHU_ST_XLATE;
          end
        end
      end
      phu_pkg::PHU_ST_XLATE: begin
        if (xlateDone) begin
          regs_next.addr     = xlatePaddr;
          regs_next.attr     = xlateAttr;
          regs_next.coherent = xlateCoherent;
          // Fault is swallowed; uncached touches nothing
          if (xlateFault || xlateUncached) begin
            regs_next.done  = 1'b1;
            regs_next.state = phu_pkg::PHU_ST_IDLE;
          end else begin
            regs_next.state = phu_pkg::PHU_ST_ISSUE;
          end
        end
      end
      phu_pkg::PHU_ST_ISSUE: begin
        if (cacheReqReady && !syncPending) begin
          regs_next.state = phu_pkg::PHU_ST_WAIT;
        end
      end
      phu_pkg::PHU_ST_WAIT: begin
        if (cacheDone) begin
          regs_next.err   = cacheBusError || cacheEccError;
          regs_next.done  = 1'b1;
          regs_next.state = phu_pkg::PHU_ST_IDLE;
        end
      end
      default: begin
        regs_next.state = phu_pkg::PHU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      regs_reg.state    <= phu_pkg::PHU_ST_IDLE;
      regs_reg.action   <= phu_pkg::PHU_ACT_NONE;
      regs_reg.place    <= phu_pkg::PHU_PLACE_NORMAL;
      regs_reg.addr     <= phu_pkg::PHU_ADDR_RESET;
      regs_reg.attr     <= 3'h0;
      regs_reg.coherent <= 1'b0;
      regs_reg.done     <= 1'b0;
      regs_reg.err      <= 1'b0;
    end else begin
      regs_reg <= regs_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign issueReady      = (regs_reg.state == phu_pkg::PHU_ST_IDLE);
  assign doneValid       = regs_reg.done;
  assign errorReport     = regs_reg.err;
  assign regWriteEnable  = 1'b0;
  assign xlateReq        = (regs_reg.state == phu_pkg::PHU_ST_XLATE);
  assign xlateVaddr      = regs_reg.addr;
  assign cacheReqValid   = (regs_reg.state == phu_pkg::PHU_ST_ISSUE) && !syncPending;
  assign cacheAction     = regs_reg.action;
  assign cachePlace      = regs_reg.place;
  assign cacheAddr       = regs_reg.addr;
  assign cacheAttr       = regs_reg.attr;
  assign cacheCoherent   = regs_reg.coherent;
  // Locked lines are exempt from every action the hierarchy takes
  assign cacheSkipLocked = 1'b1;

endmodule

// >>> tb/phu_prefetch_hint_unit_assertions.sv
// Port-level checker for the prefetch hint unit
`timescale 1ns/1ps
module phu_prefetch_hint_unit_assertions (
  // Control
  input wire logic        ref_clk, reset, issueValid, issueReady, isPrefetch, doneValid,
  input wire logic        regWriteEnable, xlateReq, xlateDone, xlateFault, xlateUncached,
  input wire logic        xlateCoherent, syncPending, cacheReqValid, cacheCoherent,
  input wire logic        cacheSkipLocked, cacheDone, cacheBusError, cacheEccError,
  input wire logic        errorReport,
  // Data
  input wire logic [31:0] issueInstr, baseValue, xlateVaddr, xlatePaddr, cacheAddr,
  input wire logic [4:0]  baseSelect,
  input wire logic [2:0]  xlateAttr, cacheAttr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire logic        take = issueValid && issueReady && isPrefetch;
  wire logic        act = issueInstr[25:21] inside {5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h07,
                                                   5'h19, 5'h1E};
  wire logic [31:0] ea = baseValue + {{20{issueInstr[11]}}, issueInstr[11:0]};
  wire logic        xok = xlateReq && xlateDone;
  AST_DECODE:
    assert property (isPrefetch == (issueInstr[31:26] == 6'h18 && issueInstr[15:12] == 4'h2))
      else $error("decode mismatch");
  AST_BASE: assert property (baseSelect == issueInstr[20:16]) else $error("base");
  AST_EADDR:
    assert property (take && act |=> xlateReq && xlateVaddr == $past(ea)) else $error("address");
  AST_NOP:
    assert property (take && !act |=> doneValid && !xlateReq) else $error("idle hint");
  AST_NO_FAULT:
    assert property (xok && (xlateFault || xlateUncached) |=>
      doneValid && !errorReport && !cacheReqValid) else $error("fault or uncached");
  AST_ATTR:
    assert property (xok && !xlateFault && !xlateUncached |=> cacheAddr == $past(xlatePaddr)
      && cacheAttr == $past(xlateAttr) && cacheCoherent == $past(xlateCoherent))
      else $error("attributes");
  AST_SYNC: assert property (cacheReqValid |-> !syncPending) else $error("sync");
  AST_ERR:
    assert property (cacheDone && (cacheBusError || cacheEccError) |=> doneValid && errorReport)
      else $error("error lost");
  AST_ERR_DONE: assert property (errorReport |-> doneValid) else $error("stray");
  AST_NO_WRITE: assert property (!regWriteEnable) else $error("reg write");
  AST_LOCKED: assert property (cacheSkipLocked) else $error("locked");
  cover property (take && !act);
  cover property (errorReport);
  cover property (xok && xlateUncached);
endmodule
bind phu_prefetch_hint_unit phu_prefetch_hint_unit_assertions phu_checker_inst (.*);

// >>> tb/phu_mem_model.sv
// Translation and cache responder beside the prefetch hint unit
`timescale 1ns/1ps
module phu_mem_model (
  // Clock and pacing
  input wire logic        ref_clk, reset, slow, xlateReq, cacheReqValid,
  input wire logic [31:0] xlateVaddr, cacheAddr,
  // Answers
  output logic            xlateDone, xlateFault, xlateUncached, xlateCoherent,
  output logic            cacheReqReady, cacheDone, cacheBusError, cacheEccError,
  output logic [31:0]     xlatePaddr,
  output logic [2:0]      xlateAttr
);
  logic [1:0] tick;
  logic       busy;
  // Stalls follow a free count, so slow answers stay bounded
  always_ff @(posedge ref_clk) begin
    tick <= reset ? 2'h0 : tick + 2'h1;
    if (reset) begin
      {xlateDone, cacheReqReady, cacheDone, busy} <= 4'h0;
    end else begin
      xlateDone <= xlateReq && !xlateDone && (!slow || tick[0]);
      cacheReqReady <= !slow || tick[1];
      if (xlateReq && !xlateDone) begin
        xlatePaddr <= xlateVaddr ^ 32'h5A5A0000;
        xlateFault <= xlateVaddr[31:30] == 2'h3;
        xlateUncached <= xlateVaddr[31:29] == 3'h5;
        {xlateCoherent, xlateAttr} <= xlateVaddr[7:4];
      end else begin
        xlatePaddr <= ~xlatePaddr;
      end
      if (cacheReqValid && cacheReqReady) begin
        busy <= 1'b1;
        {cacheEccError, cacheBusError} <= cacheAddr[3:2];
      end else if (cacheDone) begin
        busy <= 1'b0;
      end
      cacheDone <= busy && !cacheDone && (!slow || tick[0]);
    end
  end
endmodule

// >>> tb/phu_prefetch_hint_unit_bench.sv
// Self-checking bench of the prefetch hint unit
`timescale 1ns/1ps
module phu_prefetch_hint_unit_bench;
  logic ref_clk, reset, issueValid, syncPending, slow, issueReady, isPrefetch, doneValid;
  logic regWriteEnable, xlateReq, xlateDone, xlateFault, xlateUncached, xlateCoherent;
  logic cacheReqValid, cacheReqReady, cacheCoherent, cacheSkipLocked, cacheDone;
  logic cacheBusError, cacheEccError, errorReport;
  logic [31:0] issueInstr, baseValue, xlateVaddr, xlatePaddr, cacheAddr, sd;
  logic [31:0] regs [32];
  logic [4:0]  baseSelect;
  logic [2:0]  xlateAttr, cacheAttr;
  logic [40:0] cq [$];
  logic        dq [$];
  int          error_cnt = 0;
  int          checks = 0;
  phu_pkg::phu_action_type cacheAction;
  phu_pkg::phu_place_type  cachePlace;
  assign baseValue = regs[baseSelect];
  phu_prefetch_hint_unit phu_prefetch_hint_unit_inst (
    .ref_clk(ref_clk), .reset(reset), .issueValid(issueValid), .issueReady(issueReady),
    .issueInstr(issueInstr), .baseValue(baseValue), .baseSelect(baseSelect),
    .isPrefetch(isPrefetch), .doneValid(doneValid), .regWriteEnable(regWriteEnable),
    .xlateReq(xlateReq), .xlateVaddr(xlateVaddr), .xlateDone(xlateDone),
    .xlatePaddr(xlatePaddr), .xlateFault(xlateFault), .xlateUncached(xlateUncached),
    .xlateCoherent(xlateCoherent), .xlateAttr(xlateAttr), .syncPending(syncPending),
    .cacheReqValid(cacheReqValid), .cacheReqReady(cacheReqReady),
    .cacheAction(cacheAction), .cachePlace(cachePlace), .cacheAddr(cacheAddr),
    .cacheAttr(cacheAttr), .cacheCoherent(cacheCoherent),
    .cacheSkipLocked(cacheSkipLocked), .cacheDone(cacheDone),
    .cacheBusError(cacheBusError), .cacheEccError(cacheEccError),
    .errorReport(errorReport)
  );
  phu_mem_model phu_mem_model_inst (
    .ref_clk(ref_clk), .reset(reset), .slow(slow), .xlateReq(xlateReq),
    .cacheReqValid(cacheReqValid), .xlateVaddr(xlateVaddr), .cacheAddr(cacheAddr),
    .xlateDone(xlateDone), .xlateFault(xlateFault), .xlateUncached(xlateUncached),
    .xlateCoherent(xlateCoherent), .cacheReqReady(cacheReqReady), .cacheDone(cacheDone),
    .cacheBusError(cacheBusError), .cacheEccError(cacheEccError),
    .xlatePaddr(xlatePaddr), .xlateAttr(xlateAttr)
  );
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic complete_run();
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic fail(input string m);
    $display("Error %0t %s", $time, m);
    error_cnt++;
  endtask
  task automatic check_cache();
    checks++;
    if (cq.size() == 0 || cq[0] !== {cacheAction, cachePlace, cacheAddr, cacheAttr,
        cacheCoherent}) fail("cache request");
    if (cq.size() > 0) void'(cq.pop_front());
  endtask
  task automatic check_idle();
    checks++;
    if (issueReady !== 1'b1 || doneValid !== 1'b0 || cacheReqValid !== 1'b0
        || xlateReq !== 1'b0) fail("state after reset");
  endtask
  task automatic check_done();
    checks++;
    if (dq.size() == 0 || dq[0] !== errorReport) fail("completion");
    if (dq.size() > 0) void'(dq.pop_front());
  endtask
  task automatic issue(input logic [31:0] w);
    logic [31:0] va;
    logic [2:0]  act;
    logic        go;
    int          n;
    va = regs[w[20:16]] + {{20{w[11]}}, w[11:0]};
    case (w[25:21])
      5'h00, 5'h04, 5'h06: act = 3'h1;
      5'h01, 5'h05, 5'h07: act = 3'h2;
      5'h19: act = 3'h3;
      5'h1E: act = 3'h4;
      default: act = 3'h0;
    endcase
    go = act != 3'h0 && va[31:30] != 2'h3 && va[31:29] != 3'h5;
    issueValid <= 1'b1;
    issueInstr <= w;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!issueReady && n < 300);
    if (n == 300) begin
      fail("issue stalled");
      complete_run();
    end
    @(posedge ref_clk);
    if (w[15:12] == 4'h2) begin
      dq.push_back(go && va[3:2] != 2'h0);
      if (go) cq.push_back({act, w[25:22] == 4'h2 ? 2'h1 : (w[25:22] == 4'h3 ? 2'h2 : 2'h0),
                            va ^ 32'h5A5A0000, va[6:4], va[7]});
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Barrier and stall noise, so requests wait while ordering is pending
  always @(posedge ref_clk) begin
    sd <= nxt(sd);
    slow <= sd[3];
    syncPending <= sd[7] & sd[9];
  end
  always @(negedge ref_clk) begin
    if (!reset && cacheReqValid && cacheReqReady) check_cache();
    if (!reset && doneValid) check_done();
  end
  initial begin : main
    logic [31:0] r;
    logic [31:0] w;
    r = 32'h08603987;
    sd = r;
    reset = 1'b1;
    issueValid = 1'b0;
    issueInstr = 32'h0;
    slow = 1'b0;
    syncPending = 1'b0;
    foreach (regs[i]) begin
      r = nxt(r);
      regs[i] = r;
    end
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    // Every hint once, then random hints; one word with a foreign minor code
    for (int i = 0; i < 96; i++) begin
      r = nxt(r);
      w = {6'h18, ((i < 32) ? 5'(i) : r[25:21]), r[20:16], 4'h2, r[11:0]};
      if (i == 50) w[15:12] = 4'h3;
      issue(w);
    end
    issueValid <= 1'b0;
    for (int n = 0; n < 300 && cq.size() + dq.size() > 0; n++) @(posedge ref_clk);
    if (cq.size() + dq.size() > 0) fail("results missing");
    // Second reset in mid-run, then a short burst to show recovery
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    check_idle();
    @(posedge ref_clk);
    for (int i = 0; i < 16; i++) begin
      r = nxt(r);
      w = {6'h18, r[25:21], r[20:16], 4'h2, r[11:0]};
      issue(w);
    end
    issueValid <= 1'b0;
    for (int n = 0; n < 300 && cq.size() + dq.size() > 0; n++) @(posedge ref_clk);
    if (cq.size() + dq.size() > 0) fail("results missing after reset");
    complete_run();
  end
endmodule
